//--- inc/fbp_pkg.sv
// Constants for the buffer program command sequencer
// Assumes a 100 MHz system clock and the serial link in its own clock domain
`default_nettype none
package fbp_pkg;
   // ***********************************************************
   // Opcodes
   // ***********************************************************
   localparam logic [7:0] OPC_LOAD_B1     = 8'h84;
   localparam logic [7:0] OPC_LOAD_B2     = 8'h87;
   localparam logic [7:0] OPC_PGM_ERA_B1  = 8'h83;
   localparam logic [7:0] OPC_PGM_ERA_B2  = 8'h86;
   localparam logic [7:0] OPC_PGM_B1      = 8'h88;
   localparam logic [7:0] OPC_PGM_B2      = 8'h89;
   localparam logic [7:0] OPC_LD_PGM_B1   = 8'h82;
   localparam logic [7:0] OPC_LD_PGM_B2   = 8'h85;

   // ***********************************************************
   // Header and address layout
   // ***********************************************************
   localparam logic [2:0] HDR_OPC         = 3'h0;
   localparam logic [2:0] HDR_ADDR3       = 3'h3;
   localparam logic [2:0] HDR_DATA        = 3'h4;
   localparam int         PAGE264_LSB     = 9;
   localparam int         PAGE264_MSB     = 20;
   localparam int         PAGE256_LSB     = 8;
   localparam int         PAGE256_MSB     = 19;
   localparam logic [8:0] LAST_IDX_264    = 9'h107;
   localparam logic [8:0] LAST_IDX_256    = 9'h0ff;
   localparam logic [7:0] ERASED_BYTE     = 8'hff;
   localparam logic [2:0] SYNC_RST        = 3'h4;

   // ***********************************************************
   // Timing
   // ***********************************************************
   localparam int SYS_CLK_PERIOD_NS           = 10;
   localparam int ERASE_PROGRAM_TIME_LIMIT_US = 40;
   localparam int PROGRAM_TIME_LIMIT_US       = 10;
   localparam logic [11:0] EP_LIMIT_CYC =
      12'((ERASE_PROGRAM_TIME_LIMIT_US * 1000) / SYS_CLK_PERIOD_NS);
   localparam logic [11:0] P_LIMIT_CYC =
      12'((PROGRAM_TIME_LIMIT_US * 1000) / SYS_CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      S_IDLE  = 3'h0,
      S_ERASE = 3'h1,
      S_EVER  = 3'h3,
      S_PROG  = 3'h2,
      S_PVER  = 3'h6
   } fbp_seq_t;
endpackage : fbp_pkg
`default_nettype wire

//--- src/fbp_sync.sv
// Two flip-flop synchroniser for a group of levels
// Assumes each bit is a level or a toggle, stable across several clocks
`timescale 1ns/10ps
`default_nettype none
module fbp_sync #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         i_clk,    // Destination clock
   input  wire logic         i_reset,  // Sync reset, high
   input  wire logic [W-1:0] i_d,      // Asynchronous levels
   output logic      [W-1:0] o_q       // Synchronised levels
);
   logic [W-1:0] meta_q;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         meta_q <= RST;
         o_q    <= RST;
      end else begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end
endmodule : fbp_sync
`default_nettype wire

//--- src/fbp_bufmem.sv
// Two SRAM page buffers in one array, buffer select in the top address bit
// Assumes one writer and one reader on the same clock
`timescale 1ns/10ps
`default_nettype none
module fbp_bufmem (
   input  wire logic       i_clk,    // System clock
   input  wire logic       i_we,     // Write strobe
   input  wire logic [9:0] i_waddr,  // Write address
   input  wire logic [7:0] i_wdata,  // Write data
   input  wire logic [9:0] i_raddr,  // Read address
   output logic      [7:0] o_rdata   // Registered read data
);
   logic [7:0] mem [0:1023];

   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      o_rdata <= mem[i_raddr];
   end
endmodule : fbp_bufmem
`default_nettype wire

//--- src/fbp_top.sv
// Buffer load and buffer-to-page program command sequencer
// Assumes a serial host on I_CS_N/I_SCK/I_SI and a flash array port
// answering a read one system clock after the column is presented
`timescale 1ns/10ps
`default_nettype none
module fbp_top
   import fbp_pkg::*;
(
   input  wire logic        I_CLK_SYS,    // System clock
   input  wire logic        I_RESET,      // Reset, high; sync in the system domain, async in the link domain
   input  wire logic        I_SCK,        // Link serial clock
   input  wire logic        I_CS_N,       // Chip select, low active
   input  wire logic        I_SI,         // Serial data in
   input  wire logic        I_PAGE_256,   // Page size setting, high for 256
   input  wire logic [7:0]  I_ARR_RDATA,  // Array read data
   output logic             O_BUSY,       // Operation in progress
   output logic             O_ERASE_PROGRAM_ERROR_FLAG, // Erase or program verify failed, or time limit reached
   output logic [11:0]      O_ARR_PAGE,   // Array page_index
   output logic [8:0]       O_ARR_COL,    // Array byte column
   output logic [7:0]       O_ARR_WDATA,  // Array write data
   output logic             O_ARR_WE,     // Array byte program strobe
   output logic             O_ARR_ERASE   // Array page erase strobe
);
   // ***********************************************************
   // Link domain
   // ***********************************************************
   logic [2:0] bit_cnt_q;
   logic [6:0] shift_q;
   logic [7:0] rx_byte_q;
   logic       rx_tgl_q;

   // Bit counter restarts with each frame
   always_ff @(posedge I_SCK or posedge I_CS_N) begin
      if (I_CS_N) begin
         bit_cnt_q <= 3'h0;
         shift_q   <= 7'h00;
      end else begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         shift_q   <= {shift_q[5:0], I_SI};
      end
   end

   // Whole byte held, toggle announces it
   always_ff @(posedge I_SCK or posedge I_RESET) begin
      if (I_RESET) begin
         rx_byte_q <= 8'h00;
         rx_tgl_q  <= 1'b0;
      end else if (bit_cnt_q == 3'h7) begin
         rx_byte_q <= {shift_q, I_SI};
         rx_tgl_q  <= ~rx_tgl_q;
      end
   end

   // ***********************************************************
   // Crossing into the system domain
   // ***********************************************************
   logic cs_n_s;
   logic tgl_s;
   logic p256_s;
   logic cs_n_d_q;
   logic tgl_seen_q;
   logic cs_rise;
   logic cs_fall;
   logic byte_ev;

   fbp_sync #(.W(3), .RST(SYNC_RST)) fbp_sync_i (
      .i_clk   (I_CLK_SYS),
      .i_reset (I_RESET),
      .i_d     ({I_CS_N, rx_tgl_q, I_PAGE_256}),
      .o_q     ({cs_n_s, tgl_s, p256_s})
   );

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         cs_n_d_q   <= 1'b1;
         tgl_seen_q <= 1'b0;
      end else begin
         cs_n_d_q   <= cs_n_s;
         tgl_seen_q <= tgl_s;
      end
   end

   assign cs_rise = cs_n_s & ~cs_n_d_q;
   assign cs_fall = ~cs_n_s & cs_n_d_q;
   assign byte_ev = tgl_s ^ tgl_seen_q;

   // ***********************************************************
   // Command header
   // ***********************************************************
   logic        act_q;
   logic [2:0]  hdr_q;
   logic [7:0]  opc_q;
   logic [23:0] addr_q;
   logic        op_load;
   logic        op_erase;
   logic        op_pgm;
   logic        op_buf2;
   logic [11:0] page264;
   logic [11:0] page256;
   logic [8:0]  last_idx;

   always_comb begin
      op_load  = (opc_q == OPC_LOAD_B1) || (opc_q == OPC_LOAD_B2)
              || (opc_q == OPC_LD_PGM_B1) || (opc_q == OPC_LD_PGM_B2);
      op_erase = (opc_q == OPC_PGM_ERA_B1) || (opc_q == OPC_PGM_ERA_B2)
              || (opc_q == OPC_LD_PGM_B1) || (opc_q == OPC_LD_PGM_B2);
      op_pgm   = op_erase
              || (opc_q == OPC_PGM_B1) || (opc_q == OPC_PGM_B2);
      op_buf2  = (opc_q == OPC_LOAD_B2) || (opc_q == OPC_PGM_ERA_B2)
              || (opc_q == OPC_PGM_B2) || (opc_q == OPC_LD_PGM_B2);
   end

   assign page264  = addr_q[PAGE264_MSB:PAGE264_LSB];
   assign page256  = addr_q[PAGE256_MSB:PAGE256_LSB];
   assign last_idx = p256_s ? LAST_IDX_256 : LAST_IDX_264;

   // Frames opened while busy are ignored
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         act_q  <= 1'b0;
         hdr_q  <= HDR_OPC;
         opc_q  <= 8'h00;
         addr_q <= 24'h000000;
      end else if (cs_fall) begin
         act_q <= ~O_BUSY;
         hdr_q <= HDR_OPC;
      end else if (cs_rise) begin
         act_q <= 1'b0;
      end else if (byte_ev && act_q && hdr_q != HDR_DATA) begin
         hdr_q <= hdr_q + 3'h1;
         if (hdr_q == HDR_OPC) begin
            opc_q <= rx_byte_q;
         end else begin
            addr_q <= {addr_q[15:0], rx_byte_q};
         end
      end
   end

   // ***********************************************************
   // Buffer loading
   // ***********************************************************
   logic       hdr_last;
   logic       data_ev;
   logic [8:0] idx_q;

   assign hdr_last = byte_ev & act_q & (hdr_q == HDR_ADDR3);
   assign data_ev  = byte_ev & act_q & (hdr_q == HDR_DATA) & op_load;

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         idx_q <= 9'h000;
      end else if (hdr_last) begin
         idx_q <= p256_s ? {1'b0, rx_byte_q} : {addr_q[0], rx_byte_q};
      end else if (data_ev) begin
         idx_q <= (idx_q == last_idx) ? 9'h000 : idx_q + 9'h001;
      end
   end

   // ***********************************************************
   // Program sequencer
   // ***********************************************************
   fbp_seq_t    seq_q;
   logic        start;
   logic        walk_q;
   logic [8:0]  col_q;
   logic [8:0]  c1_q;
   logic        v1_q;
   logic        v2_q;
   logic        v3_q;
   logic [7:0]  exp_q;
   logic [7:0]  exp3_q;
   logic [7:0]  mem_rd;
   logic        pbuf_q;
   logic [8:0]  last_col_q;
   logic [11:0] tmr_q;
   logic [11:0] limit_q;
   logic        drained;
   logic        timeout;

   assign start   = cs_rise & act_q & (hdr_q == HDR_DATA) & op_pgm & (seq_q == S_IDLE);
   assign drained = ~walk_q & ~v1_q & ~v2_q & ~v3_q;
   assign timeout = O_BUSY & (tmr_q == limit_q);

   fbp_bufmem fbp_bufmem_i (
      .i_clk   (I_CLK_SYS),
      .i_we    (data_ev),
      .i_waddr ({op_buf2, idx_q}),
      .i_wdata (rx_byte_q),
      .i_raddr ({pbuf_q, col_q}),
      .o_rdata (mem_rd)
   );

   // Verify and program phases walk every column of the page
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         seq_q  <= S_IDLE;
         walk_q <= 1'b0;
         col_q  <= 9'h000;
      end else if (timeout) begin
         seq_q  <= S_IDLE;
         walk_q <= 1'b0;
      end else begin
         case (seq_q)
            S_IDLE: begin
               if (start) begin
                  seq_q  <= op_erase ? S_ERASE : S_PROG;
                  walk_q <= ~op_erase;
                  col_q  <= 9'h000;
               end
            end
            S_ERASE: begin
               seq_q  <= S_EVER;
               walk_q <= 1'b1;
               col_q  <= 9'h000;
            end
            S_EVER, S_PROG, S_PVER: begin
               if (walk_q) begin
                  if (col_q == last_col_q) begin
                     walk_q <= 1'b0;
                  end else begin
                     col_q <= col_q + 9'h001;
                  end
               end else if (drained) begin
                  col_q  <= 9'h000;
                  walk_q <= (seq_q != S_PVER);
                  if (seq_q == S_EVER) begin
                     seq_q <= S_PROG;
                  end else if (seq_q == S_PROG) begin
                     seq_q <= S_PVER;
                  end else begin
                     seq_q <= S_IDLE;
                  end
               end
            end
            default: begin
               seq_q  <= S_IDLE;
               walk_q <= 1'b0;
            end
         endcase
      end
   end

   // Read pipe: buffer data, then array column, then array data
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         v1_q        <= 1'b0;
         v2_q        <= 1'b0;
         v3_q        <= 1'b0;
         c1_q        <= 9'h000;
         exp_q       <= 8'h00;
         exp3_q      <= 8'h00;
         O_ARR_COL   <= 9'h000;
         O_ARR_WDATA <= 8'h00;
         O_ARR_WE    <= 1'b0;
         O_ARR_ERASE <= 1'b0;
      end else begin
         v1_q        <= walk_q & ~timeout;
         c1_q        <= col_q;
         v2_q        <= v1_q & ~timeout & ((seq_q == S_EVER) || (seq_q == S_PVER));
         exp_q       <= (seq_q == S_EVER) ? ERASED_BYTE : mem_rd;
         v3_q        <= v2_q & ~timeout;
         exp3_q      <= exp_q;
         O_ARR_COL   <= c1_q;
         O_ARR_WDATA <= mem_rd;
         O_ARR_WE    <= v1_q & ~timeout & (seq_q == S_PROG);
         O_ARR_ERASE <= (seq_q == S_ERASE) & ~timeout;
      end
   end

   // ***********************************************************
   // Busy, error flag and time limit
   // ***********************************************************
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         O_BUSY     <= 1'b0;
         O_ERASE_PROGRAM_ERROR_FLAG <= 1'b0;
         O_ARR_PAGE <= 12'h000;
         tmr_q      <= 12'h000;
         limit_q    <= 12'h000;
         pbuf_q     <= 1'b0;
         last_col_q <= 9'h000;
      end else if (start) begin
         O_BUSY     <= 1'b1;
         O_ERASE_PROGRAM_ERROR_FLAG <= 1'b0;
         O_ARR_PAGE <= p256_s ? page256 : page264;
         tmr_q      <= 12'h000;
         limit_q    <= op_erase ? EP_LIMIT_CYC : P_LIMIT_CYC;
         pbuf_q     <= op_buf2;
         last_col_q <= last_idx;
      end else if (O_BUSY) begin
         tmr_q <= tmr_q + 12'h001;
         if (timeout) begin
            O_BUSY <= 1'b0;
            O_ERASE_PROGRAM_ERROR_FLAG <= 1'b1;
         end else if (seq_q == S_PVER && drained) begin
            O_BUSY <= 1'b0;
         end
         if (v3_q && I_ARR_RDATA != exp3_q) begin
            O_ERASE_PROGRAM_ERROR_FLAG <= 1'b1;
         end
      end
   end

   // ***********************************************************
   // Checks
   // ***********************************************************
   AST_WRAP: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      data_ev && idx_q == last_idx && !hdr_last |=> idx_q == 9'h000
   ) else $error("Buffer index did not wrap to zero");
   AST_LOAD_END: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      cs_rise |=> !act_q && !data_ev
   ) else $error("Load continued after chip select rose");
   AST_IDX_264: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      hdr_last && !p256_s |=> idx_q == {$past(addr_q[0]), $past(rx_byte_q)}
   ) else $error("Wrong 9-bit start index");
   AST_IDX_256: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      hdr_last && p256_s |=> idx_q == {1'b0, $past(rx_byte_q)}
   ) else $error("Wrong 8-bit start index");
   AST_PAGE: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      start && !p256_s |=> O_ARR_PAGE == $past(page264)
   ) else $error("Wrong page index in 264 mode");
   AST_PAGE256: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      start && p256_s |=> O_ARR_PAGE == $past(page256)
   ) else $error("Wrong page index in 256 mode");
   AST_ERASE_FIRST: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      start && op_erase |=> O_BUSY && seq_q == S_ERASE ##1 O_ARR_ERASE && !O_ARR_WE
   ) else $error("Erase did not precede program");
   AST_NO_ERASE: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      start && !op_erase |=> seq_q == S_PROG ##1 (!O_ARR_ERASE && O_BUSY) [*8]
   ) else $error("Erase seen in program without erase");
   AST_VERIFY_ERR: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      O_BUSY && v3_q && I_ARR_RDATA != exp3_q && !start |=> O_ERASE_PROGRAM_ERROR_FLAG
   ) else $error("Verify mismatch not flagged");
   AST_LIMIT: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      timeout |=> !O_BUSY && O_ERASE_PROGRAM_ERROR_FLAG && seq_q == S_IDLE
   ) else $error("Time limit did not end the operation");
endmodule : fbp_top
`default_nettype wire

//--- testbench/fbp_host_model.sv
// Serial host model driving command frames into the sequencer
// Assumes mode 0 timing: clock idles low, data changes while clock is low
`timescale 1ns/10ps
`default_nettype none
module fbp_host_model (
   output logic o_sck,   // Serial clock, idle low
   output logic o_cs_n,  // Chip select, low active
   output logic o_si     // Serial data out
);
   // ***********************************************************
   // Frame driver
   // ***********************************************************
   initial begin
      o_sck  = 1'b0;
      o_cs_n = 1'b1;
      o_si   = 1'b0;
   end

   task automatic put_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         o_si = b[i];
         #24 o_sck = 1'b1;
         #24 o_sck = 1'b0;
      end
   endtask : put_byte

   task automatic frame(input logic [7:0] opc, input logic [23:0] adr,
                        input int n, input logic [7:0] base);
      o_cs_n = 1'b0;
      #24;
      put_byte(opc);
      for (int i = 0; i < 3; i++) begin
         put_byte(adr[23-8*i -: 8]);
      end
      for (int k = 0; k < n; k++) begin
         put_byte(8'(base + k));
      end
      #24 o_cs_n = 1'b1;
      // Released line shows no stale value
      o_si = ~o_si;
      #100;
   endtask : frame
endmodule : fbp_host_model
`default_nettype wire

//--- testbench/fbp_top_tb.sv
// Self-checking bench for the buffer program command sequencer
// Assumes the host model for the link and a one-page array model here
`timescale 1ns/10ps
`default_nettype none
module fbp_top_tb;
   import fbp_pkg::*;
   logic        clk;
   logic        rst;
   logic        sck;
   logic        cs_n;
   logic        si;
   logic        page_256;
   logic        busy;
   logic        ep_error;
   logic        we;
   logic        erase;
   logic        fault;
   logic        wipe = 1'b0;
   logic [7:0]  rdata = 8'h00;
   logic [7:0]  wdata;
   logic [11:0] arr_page;
   logic [8:0]  col;
   logic [7:0]  mem [264];
   logic [7:0]  exp_buf [2][264];
   int          n_fail;
   int          n_tests;
   int          n_erase = 0;
   int          n_we = 0;
   int          erase0;
   int          we0;

   fbp_top fbp_top_i (
      .I_CLK_SYS(clk), .I_RESET(rst), .I_SCK(sck), .I_CS_N(cs_n), .I_SI(si),
      .I_PAGE_256(page_256), .I_ARR_RDATA(rdata), .O_BUSY(busy),
      .O_ERASE_PROGRAM_ERROR_FLAG(ep_error),
      .O_ARR_PAGE(arr_page), .O_ARR_COL(col), .O_ARR_WDATA(wdata),
      .O_ARR_WE(we), .O_ARR_ERASE(erase));

   fbp_host_model fbp_host_model_i (.o_sck(sck), .o_cs_n(cs_n), .o_si(si));

   // ***********************************************************
   // Clock and array model
   // ***********************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Programming only clears bits, like a real cell
   always @(posedge clk) begin
      if (erase === 1'b1 || wipe === 1'b1) begin
         foreach (mem[i]) mem[i] <= ERASED_BYTE;
         n_erase <= n_erase + int'(erase === 1'b1);
      end
      if (we === 1'b1) begin
         mem[col] <= mem[col] & wdata;
         n_we <= n_we + 1;
      end
      rdata <= (col < 9'd264) ? (mem[col] ^ {7'h00, fault}) : 8'h00;
   end

   // ***********************************************************
   // Shared tasks
   // ***********************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      n_tests++;
      if (seen !== expv) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask : check

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   task automatic load(input int b, input logic [7:0] opc, input logic [23:0] adr,
                       input int n, input int start, input int np, input logic [7:0] base);
      for (int k = 0; k < n; k++) begin
         exp_buf[b][(start + k) % np] = 8'(base + k);
      end
      @(negedge clk);
      erase0 = n_erase;
      we0    = n_we;
      fbp_host_model_i.frame(opc, adr, n, base);
   endtask : load

   task automatic await_op(input logic [11:0] pg, input int ner, input logic ep,
                           input int b, input int np);
      int i;
      i = 0;
      while (busy !== 1'b1 && i < 40) begin
         @(negedge clk);
         i++;
      end
      check(busy, 1'b1);
      i = 0;
      while (busy !== 1'b0 && i < 6000) begin
         @(negedge clk);
         i++;
      end
      if (i >= 6000) begin
         n_fail++;
         wrap_up();
      end
      check(arr_page, pg);
      check(n_erase - erase0, ner);
      check(n_we - we0, np);
      check(ep_error, ep);
      for (int c = 0; c < np; c++) begin
         check(mem[c], exp_buf[b][c]);
      end
   endtask : await_op

   // ***********************************************************
   // Scenarios
   // ***********************************************************
   task automatic s_load_program;
      logic [11:0] pg;
      for (int b = 0; b < 2; b++) begin
         pg = 12'habc + 12'(b);
         load(b, b ? OPC_LOAD_B2 : OPC_LOAD_B1, {15'h7fff, 9'd260}, 264, 260, 264,
              8'(16 * b + 3));
         repeat (20) @(negedge clk);
         check(busy, 1'b0);
         load(b, b ? OPC_PGM_ERA_B2 : OPC_PGM_ERA_B1, {3'h7, pg, 9'h1ff}, 0, 0, 264,
              8'h00);
         await_op(pg, 1, 1'b0, b, 264);
      end
   endtask : s_load_program

   task automatic s_no_erase;
      logic [11:0] pg;
      for (int b = 0; b < 2; b++) begin
         pg = 12'h123 + 12'(b);
         wipe = 1'b1;
         @(negedge clk);
         wipe = 1'b0;
         load(b, b ? OPC_PGM_B2 : OPC_PGM_B1, {3'h5, pg, 9'h0aa}, 0, 0, 264, 8'h00);
         await_op(pg, 0, 1'b0, b, 264);
      end
   endtask : s_no_erase

   task automatic s_combined_256;
      logic [11:0] pg;
      page_256 = 1'b1;
      repeat (10) @(negedge clk);
      for (int b = 0; b < 2; b++) begin
         pg = 12'h5c3 ^ 12'(b);
         load(b, b ? OPC_LD_PGM_B2 : OPC_LD_PGM_B1, {4'hf, pg, 8'd250}, 256, 250, 256,
              8'(8'h40 + b));
         await_op(pg, 1, 1'b0, b, 256);
      end
      page_256 = 1'b0;
      repeat (10) @(negedge clk);
   endtask : s_combined_256

   task automatic s_fault;
      fault = 1'b1;
      load(0, OPC_PGM_ERA_B1, {3'h0, 12'h001, 9'h000}, 0, 0, 264, 8'h00);
      await_op(12'h001, 1, 1'b1, 0, 264);
      fault = 1'b0;
   endtask : s_fault

   // ***********************************************************
   // Main sequence
   // ***********************************************************
   initial begin
      n_fail   = 0;
      n_tests  = 0;
      rst      = 1'b1;
      page_256 = 1'b0;
      fault    = 1'b0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      s_load_program();
      s_no_erase();
      s_combined_256();
      s_fault();
      wrap_up();
   end
endmodule : fbp_top_tb
`default_nettype wire
